// ===== tb/ppc_load_model.sv
// behavioural model of the powered loads at the eight ports
`timescale 1ns/1ps
module ppc_load_model #(
    parameter logic [7:0] SIG_OK = 8'hF7,
    parameter logic [7:0] CHARGED = 8'h02
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // port drive from the controller
    input wire logic [15:0] probe_level_in,
    input wire logic [7:0] discharge_load_in,
    input wire logic [7:0] fet_gate_drive_in,
    // load response
    output logic [7:0] detect_valid_out,
    output logic [7:0] port_volt_high_out
);
    import ppc_pkg::*;
    logic [7:0] charge_q;
    // a powered port keeps its charge until the discharge load is applied
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            charge_q <= CHARGED;
        end else begin
            charge_q <= (charge_q & ~discharge_load_in) | fet_gate_drive_in;
        end
    end
    assign port_volt_high_out = charge_q;
    // signature only reads good under the high probe current
    always_comb begin
        for (int i = 0; i < PPC_NPORTS; i++) begin
            detect_valid_out[i] = SIG_OK[i] &&
                probe_level_in[2*i +: 2] == PPC_PROBE_HI;
        end
    end
endmodule

// ===== tb/tb.sv
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module tb;
    import ppc_pkg::*;
    localparam int BO = 100;
    localparam logic [7:0] SIG_MASK = 8'hF7;
    logic core_clk_in = 0, sys_rst_in = 1, reset_n_in = 1;
    logic fast_port_shutdown_in = 0, serial_data_in = 1;
    logic serial_data_drive_low_in = 0, supply_ok_in = 1;
    logic [3:0] bus_addr_select_in = 4'hF;
    logic [7:0] port_volt_high_in, detect_valid_in;
    logic [7:0] port_current_sense_in = 8'h00, fast_overload_in = 8'h00;
    logic [7:0] ovc_timeout_in = 8'h00, port_enable_in = 8'h00;
    logic [7:0] manual_off_in = 8'h00, int_flags_in = 8'h00;
    logic [23:0] port_prio_in = 24'h000047;
    logic [7:0] fet_gate_drive_out, discharge_load_out, bleed_res_en_out;
    logic [7:0] class_en_out, foldback_sense_out;
    logic [15:0] probe_level_out;
    logic int_oe_n_out, serial_data_oe_n_out, serial_data_rx_out;
    logic core_rst_out;
    logic [3:0] bus_addr_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;

    ppc_pin_ctrl #(.BACKOFF_CYC(BO)) ppc_pin_ctrl_inst (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .reset_n_in(reset_n_in),
        .fast_port_shutdown_in(fast_port_shutdown_in),
        .bus_addr_select_in(bus_addr_select_in),
        .serial_data_in(serial_data_in),
        .serial_data_drive_low_in(serial_data_drive_low_in),
        .supply_ok_in(supply_ok_in),
        .port_volt_high_in(port_volt_high_in),
        .detect_valid_in(detect_valid_in),
        .port_current_sense_in(port_current_sense_in),
        .fast_overload_in(fast_overload_in),
        .ovc_timeout_in(ovc_timeout_in),
        .port_enable_in(port_enable_in),
        .manual_off_in(manual_off_in),
        .port_prio_in(port_prio_in),
        .int_flags_in(int_flags_in),
        .fet_gate_drive_out(fet_gate_drive_out),
        .discharge_load_out(discharge_load_out),
        .bleed_res_en_out(bleed_res_en_out),
        .probe_level_out(probe_level_out),
        .class_en_out(class_en_out),
        .foldback_sense_out(foldback_sense_out),
        .int_oe_n_out(int_oe_n_out),
        .serial_data_oe_n_out(serial_data_oe_n_out),
        .serial_data_rx_out(serial_data_rx_out),
        .bus_addr_out(bus_addr_out),
        .core_rst_out(core_rst_out)
    );
    ppc_load_model #(.SIG_OK(SIG_MASK)) ppc_load_model_inst (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .probe_level_in(probe_level_out),
        .discharge_load_in(discharge_load_out),
        .fet_gate_drive_in(fet_gate_drive_out),
        .detect_valid_out(detect_valid_in),
        .port_volt_high_out(port_volt_high_in)
    );

    initial begin
        forever #5 core_clk_in = ~core_clk_in;
    end
    // whole plan runs near 64k cycles
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic power_up(logic [7:0] m);
        tick(1);
        port_enable_in <= m;
        for (int i = 0; i < 9000 && fet_gate_drive_out !== m; i++) begin
            tick(1);
            #1;
        end
        chk("gate_on", m, fet_gate_drive_out);
    endtask
    task automatic power_down();
        tick(1);
        port_enable_in <= 8'h00;
        tick(3);
        #1;
        chk("gate_off", 8'h00, fet_gate_drive_out);
        chk("bleed_idle", 8'hFF, bleed_res_en_out);
    endtask
    task automatic pulse_oss(int n);
        tick(1);
        fast_port_shutdown_in <= 1'b1;
        tick(n);
        fast_port_shutdown_in <= 1'b0;
        tick(400);
    endtask

    task automatic t_reset();
        tick(19);
        #1;
        chk("rst_bleed", 8'hFF, bleed_res_en_out);
        chk("rst_int", 8'h01, 8'(int_oe_n_out));
        chk("rst_core", 8'h01, 8'(core_rst_out));
        tick(1);
        sys_rst_in <= 1'b0;
        tick(40);
        #1;
        chk("por_done", 8'h00, 8'(core_rst_out));
    endtask
    task automatic t_detect();
        tick(1);
        port_enable_in <= 8'h0D;
        tick(2);
        #1;
        chk("bleed_det", 8'hF2, bleed_res_en_out);
        chk("probe_lo", 8'h01, 8'(probe_level_out[1:0]));
        tick(2050);
        #1;
        chk("probe_hi", 8'h02, 8'(probe_level_out[1:0]));
        for (int i = 0; i < 3000 && class_en_out[0] !== 1'b1; i++) begin
            tick(1);
            #1;
        end
        chk("class_multi", 8'h05, class_en_out);
        power_up(8'h0D & SIG_MASK);
        chk("bleed_on", 8'h00, bleed_res_en_out & 8'h05);
        power_down();
    endtask
    task automatic t_backoff();
        int i;
        tick(1);
        port_enable_in <= 8'h02;
        for (i = 0; i < 10 && discharge_load_out[1] !== 1'b1; i++) begin
            tick(1);
            #1;
        end
        chk("discharge", 8'h02, discharge_load_out);
        for (i = 0; i < 300 && probe_level_out[3:2] === 2'h0; i++) begin
            tick(1);
            #1;
        end
        chk("backoff", 8'h01, 8'(i >= BO - 2 && i <= BO + 10));
        power_down();
    endtask
    task automatic t_kill();
        for (int k = 0; k < 4; k++) begin
            power_up(8'h05);
            tick(1);
            case (k)
                0: supply_ok_in <= 1'b0;
                1: ovc_timeout_in <= 8'h01;
                2: manual_off_in <= 8'h01;
                default: fast_overload_in <= 8'h01;
            endcase
            tick(2);
            #1;
            chk("gate_kill", (k == 0) ? 8'h00 : 8'h04,
                fet_gate_drive_out);
            tick(1);
            supply_ok_in <= 1'b1;
            ovc_timeout_in <= 8'h00;
            manual_off_in <= 8'h00;
            fast_overload_in <= 8'h00;
            power_down();
        end
    endtask
    task automatic t_oss();
        power_up(8'h05);
        pulse_oss(50);
        tick(2500);
        #1;
        chk("oss_glitch", 8'h05, fet_gate_drive_out);
        pulse_oss(400);
        tick(2500);
        #1;
        chk("oss_one", 8'h04, fet_gate_drive_out);
        repeat (7) pulse_oss(400);
        tick(2500);
        #1;
        chk("oss_seven", 8'h00, fet_gate_drive_out);
        power_down();
        power_up(8'h01);
        power_down();
    endtask
    task automatic t_pins();
        tick(1);
        int_flags_in <= 8'h10;
        serial_data_drive_low_in <= 1'b1;
        serial_data_in <= 1'b0;
        bus_addr_select_in <= 4'hA;
        tick(4);
        #1;
        chk("int_low", 8'h00, 8'(int_oe_n_out));
        chk("sda_out", 8'h00, 8'(serial_data_oe_n_out));
        chk("sda_in", 8'h00, 8'(serial_data_rx_out));
        chk("addr", 8'h0A, 8'(bus_addr_out));
        tick(1);
        int_flags_in <= 8'h00;
        serial_data_drive_low_in <= 1'b0;
        tick(4);
        #1;
        chk("int_rel", 8'h01, 8'(int_oe_n_out));
        chk("sda_rel", 8'h01, 8'(serial_data_oe_n_out));
    endtask
    task automatic t_sense();
        tick(1);
        port_current_sense_in <= 8'h20;
        tick(100);
        port_current_sense_in <= 8'h00;
        tick(5);
        #1;
        chk("fold_glitch", 8'h00, foldback_sense_out);
        tick(1);
        port_current_sense_in <= 8'h20;
        tick(260);
        #1;
        chk("fold_on", 8'h20, foldback_sense_out);
        tick(1);
        port_current_sense_in <= 8'h00;
    endtask
    task automatic t_ext_reset();
        power_up(8'h01);
        tick(1);
        reset_n_in <= 1'b0;
        tick(100);
        reset_n_in <= 1'b1;
        tick(300);
        #1;
        chk("rst_glitch", 8'h01, fet_gate_drive_out);
        tick(1);
        reset_n_in <= 1'b0;
        tick(300);
        #1;
        chk("ext_core", 8'h01, 8'(core_rst_out));
        chk("ext_gate", 8'h00, fet_gate_drive_out);
        chk("ext_bleed", 8'hFF, bleed_res_en_out);
        tick(1);
        reset_n_in <= 1'b1;
        power_down();
    endtask

    initial begin
        t_reset();
        t_pins();
        t_sense();
        t_backoff();
        t_detect();
        t_kill();
        t_oss();
        t_ext_reset();
        end_sim();
    end
endmodule

// ===== verilog/ppc_pin_ctrl.sv
// pin-level control for an eight-port power sourcing controller
`timescale 1ns/1ps
module ppc_pin_ctrl #(
    parameter int BACKOFF_CYC = ppc_pkg::PPC_BACKOFF_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // external pins
    input wire logic reset_n_in,
    input wire logic fast_port_shutdown_in,
    input wire logic [ppc_pkg::PPC_ADDR_W-1:0] bus_addr_select_in,
    input wire logic serial_data_in,
    input wire logic serial_data_drive_low_in,
    // supply and analog comparator results
    input wire logic supply_ok_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] port_volt_high_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] detect_valid_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] port_current_sense_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] fast_overload_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] ovc_timeout_in,
    // core requests
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] port_enable_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] manual_off_in,
    input wire logic [ppc_pkg::PPC_NPORTS*3-1:0] port_prio_in,
    input wire logic [ppc_pkg::PPC_NPORTS-1:0] int_flags_in,
    // port outputs
    output logic [ppc_pkg::PPC_NPORTS-1:0] fet_gate_drive_out,
    output logic [ppc_pkg::PPC_NPORTS-1:0] discharge_load_out,
    output logic [ppc_pkg::PPC_NPORTS-1:0] bleed_res_en_out,
    output logic [ppc_pkg::PPC_NPORTS*2-1:0] probe_level_out,
    output logic [ppc_pkg::PPC_NPORTS-1:0] class_en_out,
    output logic [ppc_pkg::PPC_NPORTS-1:0] foldback_sense_out,
    // host-facing outputs
    output logic int_oe_n_out,
    output logic serial_data_oe_n_out,
    output logic serial_data_rx_out,
    output logic [ppc_pkg::PPC_ADDR_W-1:0] bus_addr_out,
    output logic core_rst_out
);
    import ppc_pkg::*;

    localparam int NP = PPC_NPORTS;

    typedef struct packed {
        logic [PPC_POR_CYC-1:0] por_sh;
        logic [1:0] rst_sync;
        logic [1:0] oss_sync;
        logic [7:0] rst_cnt;
        logic [7:0] oss_cnt;
        logic rst_filt;
        logic oss_filt;
        logic [PPC_CODE_W:0] pulse_cnt;
        logic [11:0] gap_cnt;
        logic [NP-1:0] shut_mask;
        logic [NP-1:0][PPC_CNT_W-1:0] tmr;
        logic [NP-1:0][2:0] st;
        logic [NP-1:0][7:0] sen_cnt;
        logic [NP-1:0] gate;
        logic [NP-1:0] dis;
        logic [NP-1:0] bleed;
        logic [NP-1:0][1:0] probe;
        logic [NP-1:0] cls;
        logic [NP-1:0] fold;
        logic int_oe_n;
        logic sda_oe_n;
        logic sda_rx;
        logic [PPC_ADDR_W-1:0] addr;
        logic core_rst;
    } ppc_state_t;

    ppc_state_t s_q, s_d;

    // filter step: count goes up while the input differs from the filtered level, clears when they match
    function automatic logic [7:0] ppc_filt_step(input logic lvl,
            input logic cur, input logic [7:0] cnt);
        ppc_filt_step = (lvl == cur) ? 8'h00 : cnt + 8'h01;
    endfunction

    logic por_active;
    logic hard_rst;
    logic [NP-1:0] kill;
    assign por_active = ~s_q.por_sh[PPC_POR_CYC-1];
    assign hard_rst = por_active | ~s_q.rst_filt;

    always_comb begin
        s_d = s_q;
        kill = '0;
        // internal power-on stretch independent of the reset pin
        s_d.por_sh = {s_q.por_sh[PPC_POR_CYC-2:0], 1'b1};
        // two-stage synchronisers ahead of the filters
        s_d.rst_sync = {s_q.rst_sync[0], reset_n_in};
        s_d.oss_sync = {s_q.oss_sync[0], fast_port_shutdown_in};
        // level must persist a full window before it is accepted
        s_d.rst_cnt = ppc_filt_step(s_q.rst_sync[1], s_q.rst_filt,
            s_q.rst_cnt);
        if (s_q.rst_cnt == 8'(PPC_DGL_CYC - 1)) begin
            s_d.rst_filt = s_q.rst_sync[1];
            s_d.rst_cnt = 8'h00;
        end
        // shutdown pin gets the same window as the reset pin
        s_d.oss_cnt = ppc_filt_step(s_q.oss_sync[1], s_q.oss_filt,
            s_q.oss_cnt);
        if (s_q.oss_cnt == 8'(PPC_DGL_CYC - 1)) begin
            s_d.oss_filt = s_q.oss_sync[1];
            s_d.oss_cnt = 8'h00;
        end
        // dropping the enable clears a shutdown; a code ending now still wins
        s_d.shut_mask = s_q.shut_mask & port_enable_in;
        // count rising shutdown pulses; a quiet gap ends the code
        if (s_d.oss_filt && !s_q.oss_filt) begin
            s_d.pulse_cnt = s_q.pulse_cnt + 4'h1;
            s_d.gap_cnt = '0;
        end else if (s_q.pulse_cnt != '0) begin
            s_d.gap_cnt = s_q.gap_cnt + 12'h001;
            if (s_q.gap_cnt == 12'(PPC_GAP_CYC - 1)) begin
                // n pulses shut every port whose priority is >= 8-n
                for (int i = 0; i < NP; i++) begin
                    if ({1'b0, port_prio_in[i*3 +: 3]} >=
                            4'(8) - s_q.pulse_cnt) begin
                        s_d.shut_mask[i] = 1'b1;
                    end
                end
                s_d.pulse_cnt = '0;
                s_d.gap_cnt = '0;
            end
        end
        for (int i = 0; i < NP; i++) begin
            // shutdown and manual off share the port reset path
            kill[i] = !supply_ok_in || ovc_timeout_in[i] || manual_off_in[i]
                || s_q.shut_mask[i] || !port_enable_in[i];
            // current sense glitch filter for foldback
            s_d.sen_cnt[i] = ppc_filt_step(port_current_sense_in[i],
                s_q.fold[i], s_q.sen_cnt[i]);
            if (s_q.sen_cnt[i] == 8'(PPC_SEN_CYC - 1)) begin
                s_d.fold[i] = port_current_sense_in[i];
                s_d.sen_cnt[i] = 8'h00;
            end
            s_d.tmr[i] = s_q.tmr[i] + 26'h1;
            s_d.dis[i] = 1'b0;
            s_d.probe[i] = PPC_PROBE_OFF;
            s_d.cls[i] = 1'b0;
            case (ppc_port_st_t'(s_q.st[i]))
                PPC_IDLE: begin
                    s_d.tmr[i] = '0;
                    if (!kill[i]) begin
                        s_d.st[i] = port_volt_high_in[i] ? 3'(PPC_BACKOFF)
                            : 3'(PPC_PROBE1);
                    end
                end
                PPC_BACKOFF: begin
                    // discharge load during backoff
                    s_d.dis[i] = 1'b1;
                    if (s_q.tmr[i] >= 26'(BACKOFF_CYC - 1)) begin
                        s_d.st[i] = 3'(PPC_PROBE1);
                        s_d.tmr[i] = '0;
                    end
                end
                PPC_PROBE1: begin
                    // first probe current level
                    s_d.probe[i] = PPC_PROBE_LO;
                    if (s_q.tmr[i] >= 26'(PPC_GAP_CYC - 1)) begin
                        s_d.st[i] = 3'(PPC_PROBE2);
                        s_d.tmr[i] = '0;
                    end
                end
                PPC_PROBE2: begin
                    s_d.probe[i] = PPC_PROBE_HI;
                    if (s_q.tmr[i] >= 26'(PPC_GAP_CYC - 1)) begin
                        // invalid signature never reaches power
                        s_d.st[i] = detect_valid_in[i] ? 3'(PPC_CLASS)
                            : 3'(PPC_IDLE);
                        s_d.tmr[i] = '0;
                    end
                end
                PPC_CLASS: begin
                    // per-port, so many ports classify at once
                    s_d.cls[i] = 1'b1;
                    if (s_q.tmr[i] >= 26'(PPC_GAP_CYC - 1)) begin
                        s_d.st[i] = 3'(PPC_ON);
                    end
                end
                PPC_ON: s_d.tmr[i] = '0;
                default: s_d.st[i] = 3'(PPC_IDLE);
            endcase
            if (kill[i]) begin
                s_d.st[i] = 3'(PPC_IDLE);
            end
            // registered off within 1 us of overload
            s_d.gate[i] = (ppc_port_st_t'(s_d.st[i]) == PPC_ON)
                && !fast_overload_in[i] && !kill[i];
            if (fast_overload_in[i]) begin
                s_d.st[i] = 3'(PPC_IDLE);
            end
            // bleed resistor off only while detecting or on
            s_d.bleed[i] = !(s_d.st[i] == 3'(PPC_PROBE1) ||
                s_d.st[i] == 3'(PPC_PROBE2) || s_d.st[i] == 3'(PPC_ON));
        end
        // open drain interrupt pulls low while any flag is set
        s_d.int_oe_n = ~|int_flags_in;
        // separate rx and open-drain tx lines
        s_d.sda_oe_n = ~serial_data_drive_low_in;
        s_d.sda_rx = serial_data_in;
        // address straps; open pins read high via pull-ups
        s_d.addr = bus_addr_select_in;
        s_d.core_rst = hard_rst;
        if (hard_rst) begin
            // ports off and state back to power-up
            s_d.st = '0;
            s_d.tmr = '0;
            s_d.gate = '0;
            s_d.dis = '0;
            s_d.bleed = '1;
            s_d.probe = '0;
            s_d.cls = '0;
            s_d.shut_mask = '0;
            s_d.pulse_cnt = '0;
            s_d.gap_cnt = '0;
            s_d.sda_oe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.rst_sync <= 2'h3;
            s_q.rst_filt <= 1'b1;
            s_q.bleed <= '1;
            s_q.int_oe_n <= 1'b1;
            s_q.sda_oe_n <= 1'b1;
            s_q.sda_rx <= 1'b1;
            s_q.core_rst <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign fet_gate_drive_out = s_q.gate;
    assign discharge_load_out = s_q.dis;
    assign bleed_res_en_out = s_q.bleed;
    assign probe_level_out = s_q.probe;
    assign class_en_out = s_q.cls;
    assign foldback_sense_out = s_q.fold;
    assign int_oe_n_out = s_q.int_oe_n;
    assign serial_data_oe_n_out = s_q.sda_oe_n;
    assign serial_data_rx_out = s_q.sda_rx;
    assign bus_addr_out = s_q.addr;
    assign core_rst_out = s_q.core_rst;

    a_gate_kill: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        (!supply_ok_in || ovc_timeout_in != '0) |=>
        (fet_gate_drive_out & $past(ovc_timeout_in)) == '0 &&
        ($past(supply_ok_in) || fet_gate_drive_out == '0))
        else $error("gate on after supply loss or timeout");
    a_gate_manual: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        manual_off_in[0] |=> !fet_gate_drive_out[0])
        else $error("gate on while manually off");
    a_fast_off: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        fast_overload_in[0] |-> ##[1:2] !fet_gate_drive_out[0])
        else $error("fast overload not acted on");
    a_int_pin: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        ##1 int_oe_n_out == !$past(|int_flags_in))
        else $error("interrupt pin wrong");
    a_bleed_rule: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        fet_gate_drive_out[0] |-> !bleed_res_en_out[0])
        else $error("bleed resistor on while port on");
    a_rst_ports: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        core_rst_out |-> fet_gate_drive_out == '0)
        else $error("ports on during reset");
    // the filtered level may only move after a full quiet window
    a_rst_glitch: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        $changed(s_q.rst_filt) |->
        $past(s_q.rst_cnt) == 8'(PPC_DGL_CYC - 1))
        else $error("reset glitch passed filter");
    a_probe_gate: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        $rose(fet_gate_drive_out[0]) |-> $past(class_en_out[0], 2)
        || $past(class_en_out[0], 1))
        else $error("port powered without discovery");
    a_discharge: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        discharge_load_out[0] |-> !fet_gate_drive_out[0] &&
        probe_level_out[1:0] == PPC_PROBE_OFF)
        else $error("discharge overlaps probing");
endmodule

// ===== verilog/ppc_pkg.sv
// shared constants for the port pin control block
package ppc_pkg;
    localparam int PPC_CLK_MHZ = 100;
    localparam int PPC_NPORTS = 8;
    localparam int PPC_ADDR_W = 4;
    // deglitch window, accepted between 1 us and 5 us
    localparam int PPC_DGL_NS = 2000;
    localparam int PPC_DGL_CYC = (PPC_DGL_NS * PPC_CLK_MHZ) / 1000;
    // current sense glitch filter
    localparam int PPC_SEN_NS = 2000;
    localparam int PPC_SEN_CYC = (PPC_SEN_NS * PPC_CLK_MHZ) / 1000;
    // fast overload must act within 1 us
    localparam int PPC_FAST_NS = 1000;
    localparam int PPC_FAST_CYC = (PPC_FAST_NS * PPC_CLK_MHZ) / 1000;
    // detect backoff
    localparam int PPC_BACKOFF_MS = 400;
    localparam int PPC_BACKOFF_CYC = PPC_BACKOFF_MS * PPC_CLK_MHZ * 1000;
    // pulse code: gap that ends a code word
    localparam int PPC_GAP_NS = 20000;
    localparam int PPC_GAP_CYC = (PPC_GAP_NS * PPC_CLK_MHZ) / 1000;
    // power-on reset stretch
    localparam int PPC_POR_CYC = 16;
    localparam int PPC_CODE_W = 3;
    localparam int PPC_CNT_W = 26;
    localparam logic [1:0] PPC_PROBE_OFF = 2'h0;
    localparam logic [1:0] PPC_PROBE_LO = 2'h1;
    localparam logic [1:0] PPC_PROBE_HI = 2'h2;
    typedef enum {
        PPC_IDLE, PPC_BACKOFF, PPC_PROBE1, PPC_PROBE2, PPC_CLASS, PPC_ON
    } ppc_port_st_t;
endpackage
